// ### core/psia_pkg.sv
package psia_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int PC_W        = 13;
   localparam int HI_W        = 5;
   localparam int DAT_W       = 8;
   localparam int EA_W        = 9;
   localparam int OPND_W      = 11;
   localparam int STK_DEPTH   = 8;
   localparam int STK_PTR_W   = 3;
   localparam int ADR_W       = 4;

   // ****************************************************************
   // Register offsets and reset values
   // ****************************************************************
   localparam logic [ADR_W-1:0] OFS_PC_LOW     = 4'h0;
   localparam logic [ADR_W-1:0] OFS_HIGH_LATCH = 4'h1;
   localparam logic [ADR_W-1:0] OFS_FILE_PTR   = 4'h2;
   localparam logic [ADR_W-1:0] OFS_BANK_CTRL  = 4'h3;
   localparam logic [ADR_W-1:0] OFS_PC_STATUS  = 4'h4;
   localparam logic [DAT_W-1:0] INDIRECT_LOC   = 8'h00;
   localparam logic [DAT_W-1:0] INDIRECT_READ  = 8'h00;
   localparam logic [HI_W-1:0]  HIGH_LATCH_RST = 5'h00;
   localparam logic [PC_W-1:0]  PC_RST         = 13'h0000;
   localparam logic [DAT_W-1:0] FILE_PTR_RST   = 8'h00;
   localparam logic [DAT_W-1:0] RD_ZERO        = 8'h00;
   localparam int BANK_BIT_POS  = 0;
   localparam int JMP_HI_LSB    = 3;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [4:0]
   {
      PSIA_OP_STEP   = 5'b00001,
      PSIA_OP_BRANCH = 5'b00010,
      PSIA_OP_CALL   = 5'b00100,
      PSIA_OP_RETURN = 5'b01000,
      PSIA_OP_IRQ    = 5'b10000
   } psia_op_t;

   typedef struct packed
   {
      logic             valid;
      psia_op_t         op;
      logic [OPND_W-1:0] operand;
      logic [PC_W-1:0]  irq_vector;
   } psia_seq_t;

   typedef struct packed
   {
      logic             valid;
      logic             write;
      logic [DAT_W-1:0] wdata;
   } psia_ind_t;

endpackage : psia_pkg

// ### core/psia_stack.sv
`timescale 1ns/1ps
`default_nettype none
module psia_stack
   import psia_pkg::*;
#(
   parameter int DEPTH = STK_DEPTH
)
(
   input  wire logic            clock_in,
   input  wire logic            reset_n_in,
   input  wire logic            push_in,
   input  wire logic            pop_in,
   input  wire logic [PC_W-1:0] push_data_in,
   output logic      [PC_W-1:0] top_out
);
   // Pointer width is fixed, so only a depth that fills it wraps correctly
   if (DEPTH != (1 << STK_PTR_W))
   begin : g_depth_bad
      $error("stack depth must equal two to the pointer width");
   end

   typedef struct packed
   {
      logic [STK_PTR_W-1:0]        ptr;
      logic [DEPTH-1:0][PC_W-1:0]  mem;
   } psia_stk_state_t;

   psia_stk_state_t st_r;
   psia_stk_state_t st_nxt;

   // Pointer wraps silently; no overflow state exists to report
   always_comb
   begin
      st_nxt = st_r;
      if (push_in)
      begin
         st_nxt.mem[st_r.ptr] = push_data_in;
         st_nxt.ptr           = st_r.ptr + 3'h1;
      end
      else if (pop_in)
      begin
         st_nxt.ptr = st_r.ptr - 3'h1;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign top_out = st_r.mem[st_r.ptr - 3'h1];
endmodule : psia_stack
`default_nettype wire

// ### core/psia_indirect.sv
`timescale 1ns/1ps
`default_nettype none
module psia_indirect
   import psia_pkg::*;
(
   input  wire logic             bank_in,
   input  wire logic [DAT_W-1:0] file_ptr_in,
   input  wire psia_ind_t        req_in,
   output logic      [EA_W-1:0]  addr_out,
   output logic                  self_out,
   output logic                  wr_en_out
);
   // Pure decode so the result lines up with the requesting cycle
   always_comb
   begin
      addr_out  = {bank_in, file_ptr_in};
      self_out  = (file_ptr_in == INDIRECT_LOC);
      wr_en_out = req_in.valid && req_in.write && !self_out;
   end
endmodule : psia_indirect
`default_nettype wire

// ### core/psia_core.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - The counter is 13 bits, its low byte reads and writes, its top five come from the latch.
// - Reset clears the whole counter to zero.
// - Writing the low byte loads the top five counter bits from the latch at the same time.
// - Call or jump takes eleven bits from the operand and the top two from latch bits 4:3.
// - A step that rolls the low byte over carries into the upper counter bits.
// - An eight-deep 13-bit return stack sits outside all maps with a hidden pointer.
// - Call and interrupt push the counter; the return pops into it.
// - Push and pop leave the latch alone.
// - The stack wraps, the ninth push overwriting the first.
// - No flag reports stack overflow or underflow.
// - The indirect port has no storage and reaches the location the file pointer names.
// - Reading the indirect port through itself yields 00h.
// - Writing the indirect port through itself stores nothing.
// - The indirect address is the bank bit joined above the eight pointer bits.
// - The latch holds five bits and resets to zero.
module psia_core
   import psia_pkg::*;
(
   input  wire logic              clock_in,
   input  wire logic              reset_n_in,
   input  wire logic [ADR_W-1:0]  reg_addr_in,
   input  wire logic [DAT_W-1:0]  reg_wdata_in,
   input  wire logic              reg_wr_in,
   input  wire logic              reg_rd_in,
   output logic      [DAT_W-1:0]  reg_rdata_out,
   input  wire psia_seq_t         seq_in,
   input  wire psia_ind_t         ind_in,
   input  wire logic [DAT_W-1:0]  ind_mem_rdata_in,
   output logic      [PC_W-1:0]   pc_out,
   output logic      [EA_W-1:0]   ind_addr_out,
   output logic                   ind_wr_out,
   output logic      [DAT_W-1:0]  ind_wdata_out,
   output logic      [DAT_W-1:0]  ind_rdata_out
);
   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed
   {
      logic [PC_W-1:0]  pc;
      logic [HI_W-1:0]  high_latch;
      logic [DAT_W-1:0] file_ptr;
      logic             bank;
      logic [DAT_W-1:0] rdata;
      logic [EA_W-1:0]  ind_addr;
      logic             ind_wr;
      logic [DAT_W-1:0] ind_wdata;
      logic [DAT_W-1:0] ind_rdata;
   } psia_core_state_t;

   psia_core_state_t st_r;
   psia_core_state_t st_nxt;

   logic             push;
   logic             pop;
   logic [PC_W-1:0]  stk_top;
   logic [EA_W-1:0]  ea;
   logic             ea_self;
   logic             ea_wr;
   logic             low_wr;

   // ****************************************************************
   // Return stack and indirect decode
   // ****************************************************************
   // Stack has no status port at all
   psia_stack #(.DEPTH(STK_DEPTH)) u_stack
   (
      .clock_in     (clock_in),
      .reset_n_in   (reset_n_in),
      .push_in      (push),
      .pop_in       (pop),
      .push_data_in (st_r.pc),
      .top_out      (stk_top)
   );

   psia_indirect u_indirect
   (
      .bank_in     (st_r.bank),
      .file_ptr_in (st_r.file_ptr),
      .req_in      (ind_in),
      .addr_out    (ea),
      .self_out    (ea_self),
      .wr_en_out   (ea_wr)
   );

   // Call and interrupt push the current counter value, not the following address
   assign push   = seq_in.valid && (seq_in.op == PSIA_OP_CALL || seq_in.op == PSIA_OP_IRQ);
   assign pop    = seq_in.valid && seq_in.op == PSIA_OP_RETURN;
   assign low_wr = reg_wr_in && reg_addr_in == OFS_PC_LOW;

   // ****************************************************************
   // Next state
   // ****************************************************************
   always_comb
   begin
      st_nxt       = st_r;
      st_nxt.rdata = RD_ZERO;
      st_nxt.ind_wr = 1'b0;
      // Register writes; latch only changes here, never on stack traffic
      if (reg_wr_in)
      begin
         case (reg_addr_in)
            OFS_HIGH_LATCH : st_nxt.high_latch = reg_wdata_in[HI_W-1:0];
            OFS_FILE_PTR   : st_nxt.file_ptr   = reg_wdata_in;
            OFS_BANK_CTRL  : st_nxt.bank       = reg_wdata_in[BANK_BIT_POS];
            default        : ;
         endcase
      end
      if (reg_rd_in)
      begin
         case (reg_addr_in)
            OFS_PC_LOW     : st_nxt.rdata = st_r.pc[DAT_W-1:0];
            OFS_FILE_PTR   : st_nxt.rdata = st_r.file_ptr;
            OFS_BANK_CTRL  : st_nxt.rdata = {7'h00, st_r.bank};
            OFS_PC_STATUS  : st_nxt.rdata = {3'h0, st_r.pc[PC_W-1:DAT_W]};
            default        : st_nxt.rdata = RD_ZERO;
         endcase
      end
      // Low-byte write beats sequencing since it is the instruction's own result
      if (low_wr)
      begin
         st_nxt.pc = {st_r.high_latch, reg_wdata_in};
      end
      else if (seq_in.valid)
      begin
         case (seq_in.op)
            PSIA_OP_STEP   : st_nxt.pc = st_r.pc + 13'h0001;
            PSIA_OP_BRANCH,
            PSIA_OP_CALL   : st_nxt.pc = {st_r.high_latch[HI_W-1:JMP_HI_LSB],
                                          seq_in.operand};
            PSIA_OP_RETURN : st_nxt.pc = stk_top;
            PSIA_OP_IRQ    : st_nxt.pc = seq_in.irq_vector;
            default        : st_nxt.pc = st_r.pc;
         endcase
      end
      // Indirect port: no storage, self-address reads zero and drops writes
      st_nxt.ind_addr  = ea;
      st_nxt.ind_wdata = ind_in.wdata;
      st_nxt.ind_wr    = ea_wr;
      if (ind_in.valid && !ind_in.write)
      begin
         st_nxt.ind_rdata = ea_self ? INDIRECT_READ : ind_mem_rdata_in;
      end
   end

   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         st_r            <= '0;
         st_r.pc         <= PC_RST;
         st_r.high_latch <= HIGH_LATCH_RST;
         st_r.file_ptr   <= FILE_PTR_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata_out = st_r.rdata;
   assign pc_out        = st_r.pc;
   assign ind_addr_out  = st_r.ind_addr;
   assign ind_wr_out    = st_r.ind_wr;
   assign ind_wdata_out = st_r.ind_wdata;
   assign ind_rdata_out = st_r.ind_rdata;
endmodule : psia_core
`default_nettype wire

// ### tb/psia_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Sequencer, low-byte write and indirect port checks
// ********************
module psia_core_chk
   import psia_pkg::*;
(
   input wire logic             clock_in,
   input wire logic             reset_n_in,
   input wire logic [ADR_W-1:0] reg_addr_in,
   input wire logic [DAT_W-1:0] reg_wdata_in,
   input wire logic             reg_wr_in,
   input wire logic             reg_rd_in,
   input wire logic [DAT_W-1:0] reg_rdata_out,
   input wire psia_seq_t        seq_in,
   input wire psia_ind_t        ind_in,
   input wire logic [DAT_W-1:0] ind_mem_rdata_in,
   input wire logic [PC_W-1:0]  pc_out,
   input wire logic [EA_W-1:0]  ind_addr_out,
   input wire logic             ind_wr_out,
   input wire logic [DAT_W-1:0] ind_wdata_out,
   input wire logic [DAT_W-1:0] ind_rdata_out
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);
   // Low-byte write beats any instruction in the same cycle
   logic lw;
   assign lw = reg_wr_in && reg_addr_in == OFS_PC_LOW;
   sequence s_call;
      seq_in.valid && seq_in.op == PSIA_OP_CALL && !lw;
   endsequence
   sequence s_ret;
      seq_in.valid && seq_in.op == PSIA_OP_RETURN && !lw;
   endsequence
   low_write_a: assert property (lw |=> pc_out[7:0] == $past(reg_wdata_in))
      else $error("low byte not loaded");
   jump_load_a: assert property (seq_in.valid && !lw && seq_in.op inside {
      PSIA_OP_BRANCH, PSIA_OP_CALL} |=> pc_out[10:0] == $past(seq_in.operand))
      else $error("jump operand not loaded");
   step_one_a: assert property (seq_in.valid && seq_in.op == PSIA_OP_STEP && !lw
      |=> pc_out == $past(pc_out) + 13'h0001) else $error("step not by one");
   pc_hold_a: assert property (!seq_in.valid && !lw |=> $stable(pc_out))
      else $error("counter moved while idle");
   irq_vector_a: assert property (seq_in.valid && seq_in.op == PSIA_OP_IRQ && !lw
      |=> pc_out == $past(seq_in.irq_vector)) else $error("vector not taken");
   call_return_a: assert property (s_call ##1 s_ret |=> pc_out == $past(pc_out, 2))
      else $error("return address wrong");
   ind_write_a: assert property (ind_wr_out |-> ind_addr_out[7:0] != INDIRECT_LOC
      && $past(ind_in.valid && ind_in.write) && ind_wdata_out == $past(ind_in.wdata))
      else $error("bad indirect write");
   self_read_a: assert property ($past(ind_in.valid && !ind_in.write) &&
      ind_addr_out[7:0] == INDIRECT_LOC |-> ind_rdata_out == INDIRECT_READ)
      else $error("self read not zero");
endmodule : psia_core_chk
bind psia_core psia_core_chk i_psia_core_chk (.clock_in, .reset_n_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .seq_in, .ind_in, .ind_mem_rdata_in,
   .pc_out, .ind_addr_out, .ind_wr_out, .ind_wdata_out, .ind_rdata_out);
`default_nettype wire

// ### tb/psia_dmem.sv
`timescale 1ns/1ps
`default_nettype none
// ********************
// Data memory behind the indirect port
// ********************
module psia_dmem
   import psia_pkg::*;
(
   input  wire logic [EA_W-1:0]  addr_in,
   output logic      [DAT_W-1:0] rdata_out
);
   // Every location within a bank differs, so a wrong pointer shows
   assign rdata_out = addr_in[7:0] ^ {addr_in[8], 7'h5A};
endmodule : psia_dmem
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %0t: got %h want %h", $time, g, e); end end
module tb
   import psia_pkg::*;
;
   // ********************
   // Stimulus and model
   // ********************
   logic                 clock_in = 1'h0, reset_n_in = 1'h0, reg_wr_in = 1'h0, reg_rd_in = 1'h0;
   logic [ADR_W-1:0]     reg_addr_in = 4'h0;
   logic [DAT_W-1:0]     reg_wdata_in = 8'h00, fp = 8'h00, b, ind_mem_rdata_in, reg_rdata_out;
   logic [DAT_W-1:0]     ind_wdata_out, ind_rdata_out;
   psia_seq_t            seq_in = '0;
   psia_ind_t            ind_in = '0;
   logic [PC_W-1:0]      pc_out, m_pc = 13'h0000, stk [STK_DEPTH];
   logic [EA_W-1:0]      ind_addr_out;
   logic                 ind_wr_out, bank = 1'h0;
   logic [STK_PTR_W-1:0] sp = 3'h0;
   logic [HI_W-1:0]      lat = 5'h00;
   int                   seed = 32'h2C2BC6BE, bad_count = 0, comparisons = 0;
   psia_core i_psia_core (.clock_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
      .reg_rd_in, .reg_rdata_out, .seq_in, .ind_in, .ind_mem_rdata_in, .pc_out,
      .ind_addr_out, .ind_wr_out, .ind_wdata_out, .ind_rdata_out);
   psia_dmem i_psia_dmem (.addr_in({bank, fp}), .rdata_out(ind_mem_rdata_in));
   always #25 clock_in = ~clock_in;
   // One driver sets every request signal once per cycle, so requests run back to back
   task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d,
      input psia_seq_t s, input psia_ind_t n);
      reg_wr_in <= w;
      reg_rd_in <= r;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      seq_in <= s;
      ind_in <= n;
      @(posedge clock_in);
      #1;
   endtask : cyc
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      cyc(1'h1, 1'h0, a, d, '0, '0);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      cyc(1'h0, 1'h1, a, 8'h00, '0, '0);
      `CHK(reg_rdata_out, e)
   endtask : rd
   function automatic logic [PC_W-1:0] nxt(psia_op_t o, logic [10:0] x, logic [12:0] v);
      if (o == PSIA_OP_STEP)
         return m_pc + 13'h0001;
      if (o == PSIA_OP_IRQ)
         return v;
      return {lat[4:3], x};
   endfunction : nxt
   task automatic op(input psia_op_t o, input logic [10:0] x, input logic [12:0] v);
      cyc(1'h0, 1'h0, 4'h0, 8'h00, '{1'h1, o, x, v}, '0);
      if (o == PSIA_OP_CALL || o == PSIA_OP_IRQ)
      begin
         stk[sp] = m_pc;
         sp++;
      end
      if (o == PSIA_OP_RETURN)
      begin
         sp--;
         m_pc = stk[sp];
      end
      else
         m_pc = nxt(o, x, v);
      `CHK(pc_out, m_pc)
   endtask : op
   task automatic ind(input logic w, input logic [7:0] d);
      cyc(1'h0, 1'h0, 4'h0, 8'h00, '0, '{1'h1, w, d});
      `CHK(ind_addr_out, {bank, fp})
      if (w)
      begin
         `CHK(ind_wr_out, fp != INDIRECT_LOC)
         `CHK(ind_wdata_out, d)
      end
      else
         `CHK(ind_rdata_out, (fp == INDIRECT_LOC) ? INDIRECT_READ : fp ^ {bank, 7'h5A})
   endtask : ind
   task automatic stop_test;
      $display("Compared %0d, mismatched %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   initial
   begin
      repeat (4000) @(posedge clock_in);
      bad_count++;
      stop_test();
   end
   initial
   begin
      repeat (16) @(posedge clock_in);
      `CHK(pc_out, PC_RST)
      reset_n_in <= 1'h1;
      for (int i = 0; i < 4; i++)
      begin
         lat = 5'($random(seed));
         b = (i == 0) ? 8'hFF : 8'($random(seed));
         wr(OFS_HIGH_LATCH, {3'h0, lat});
         wr(OFS_PC_LOW, b);
         m_pc = {lat, b};
         `CHK(pc_out, m_pc)
         rd(OFS_PC_LOW, b);
         rd(OFS_PC_STATUS, {3'h0, lat});
         rd(OFS_HIGH_LATCH, RD_ZERO);
         rd(4'hF, RD_ZERO);
         op(PSIA_OP_STEP, 11'h000, 13'h0000);
         op(PSIA_OP_BRANCH, 11'($random(seed)), 13'h0000);
      end
      $display("Counter loading test done");
      // Ten calls overrun the eight entries, so the returns show the wrap
      for (int i = 0; i < 18; i++)
         op((i < 10) ? PSIA_OP_CALL : PSIA_OP_RETURN, 11'($random(seed)), 13'h0000);
      op(PSIA_OP_IRQ, 11'h000, 13'($random(seed)));
      op(PSIA_OP_RETURN, 11'h000, 13'h0000);
      b = 8'($random(seed));
      wr(OFS_PC_LOW, b);
      `CHK(pc_out, {lat, b})
      $display("Stack test done");
      // Reset in mid-run must clear the counter and the latch again
      reset_n_in <= 1'h0;
      cyc(1'h0, 1'h0, 4'h0, 8'h00, '0, '0);
      `CHK(pc_out, PC_RST)
      lat = HIGH_LATCH_RST;
      sp = 3'h0;
      b = 8'($random(seed));
      reset_n_in <= 1'h1;
      wr(OFS_PC_LOW, b);
      `CHK(pc_out, {lat, b})
      $display("Reset test done");
      for (int i = 0; i < 6; i++)
      begin
         fp = (i < 2) ? INDIRECT_LOC : 8'($random(seed));
         bank = (i == 5);
         wr(OFS_FILE_PTR, fp);
         wr(OFS_BANK_CTRL, {7'h00, bank});
         ind(1'h0, 8'h00);
         ind(1'h1, 8'($random(seed)));
      end
      bank = 1'h0;
      wr(OFS_BANK_CTRL, 8'h00);
      $display("Indirect test done");
      stop_test();
   end
endmodule : tb
`default_nettype wire
